/* core/dtc_pkg.sv */
package dtc_pkg;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] DTC_ADDR_CTRL  = 8'h88;
    localparam logic [7:0] DTC_ADDR_MODE  = 8'h89;
    localparam logic [7:0] DTC_ADDR_LOW0  = 8'h8a;
    localparam logic [7:0] DTC_ADDR_LOW1  = 8'h8b;
    localparam logic [7:0] DTC_ADDR_HIGH0 = 8'h8c;
    localparam logic [7:0] DTC_ADDR_HIGH1 = 8'h8d;
    localparam logic [7:0] DTC_ADDR_CKDIV = 8'h8e;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] DTC_RST_CTRL  = 8'h00;
    localparam logic [7:0] DTC_RST_MODE  = 8'h00;
    localparam logic [7:0] DTC_RST_COUNT = 8'h00;
    localparam logic [4:0] DTC_RST_CKDIV = 5'h01;
    localparam logic [1:0] DTC_RST_PIN   = 2'h3;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int DTC_CTRL_OVF1  = 7;
    localparam int DTC_CTRL_RUN1  = 6;
    localparam int DTC_CTRL_OVF0  = 5;
    localparam int DTC_CTRL_RUN0  = 4;
    localparam int DTC_CTRL_IRQF1 = 3;
    localparam int DTC_CTRL_IRQT1 = 2;
    localparam int DTC_CTRL_IRQF0 = 1;
    localparam int DTC_CTRL_IRQT0 = 0;
    localparam int DTC_MODE_GATE  = 3;
    localparam int DTC_MODE_CT    = 2;
    localparam int DTC_CKDIV_SEL1 = 4;
    localparam int DTC_CKDIV_SEL0 = 3;

    // ************************************************************
    // clock divider counts
    // ************************************************************
    localparam logic [3:0] DTC_DIV_SLOW = 4'd12;
    localparam logic [1:0] DTC_DIV_FAST_LAST = 2'h3;

    typedef enum logic [1:0] {
        DTC_MODE_PRESCALE = 2'b00,
        DTC_MODE_FULL16   = 2'b01,
        DTC_MODE_RELOAD   = 2'b10,
        DTC_MODE_SPLIT    = 2'b11
    } dtc_mode_t;

endpackage

/* core/dtc_tick_if.sv */
`timescale 1ns/1ns
interface dtc_tick_if;
    logic       tick_div12;
    logic       tick_div4;
    logic [1:0] count_pin;
    logic [1:0] count_fall;

    modport gen (output tick_div12, output tick_div4, output count_fall, input count_pin);
    modport use_side (input tick_div12, input tick_div4, input count_fall, output count_pin);
endinterface

/* core/dtc_tick_gen.sv */
`timescale 1ns/1ns
module dtc_tick_gen (
    // clock and reset
    input  wire logic mclk,
    input  wire logic reset_n,
    // ticks and count pin edges
    dtc_tick_if.gen   tk
);
    import dtc_pkg::*;

    logic [3:0] div_q;
    logic [3:0] div_d;
    logic [1:0] pin_prev_q;
    logic [1:0] pin_prev_d;

    // ************************************************************
    // free divider: one shared counter serves both rates
    // ************************************************************
    always_comb begin
        div_d      = (div_q == DTC_DIV_SLOW - 4'd1) ? 4'h0 : div_q + 4'd1;
        pin_prev_d = tk.count_pin;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            div_q      <= 4'h0;
            pin_prev_q <= DTC_RST_PIN;
        end else begin
            div_q      <= div_d;
            pin_prev_q <= pin_prev_d;
        end
    end

    // 12 is a multiple of 4, so the fast tick stays evenly spaced across the wrap
    assign tk.tick_div12 = (div_q == DTC_DIV_SLOW - 4'd1);
    assign tk.tick_div4  = (div_q[1:0] == DTC_DIV_FAST_LAST);
    assign tk.count_fall = pin_prev_q & ~tk.count_pin;

    // ************************************************************
    // checks
    // ************************************************************
    a_div12_spacing: assert property (@(posedge mclk) disable iff (!reset_n) // [R10]
        tk.tick_div12 |-> ##12 tk.tick_div12) else $error("slow tick not every 12 clocks");
    a_div4_spacing: assert property (@(posedge mclk) disable iff (!reset_n) // [R9]
        tk.tick_div4 |=> !tk.tick_div4 [*3] ##1 tk.tick_div4) else $error("fast tick not every 4");
endmodule

/* core/dtc_timer_unit.sv */
`timescale 1ns/1ns
// Contract
// [R1] timer one gate clear: counts whenever its run bit is set
// [R2] timer zero gate set: counts only with run bit set and gate pin high
// [R3] timer one counter-select 1 counts count pin pulses, 0 counts internal clocks
// [R4] timer zero counter-select 1 counts count pin pulses, 0 counts internal clocks
// [R5] mode 00 is 8-bit counter with 5-bit prescaler; mode 01 is 16-bit
// [R6] mode 10 is 8-bit counter, low byte reloaded from high byte on overflow
// [R7] mode 11 halts timer one while keeping its count
// [R8] mode 11 splits timer zero into two 8-bit counters
// [R9] timer one clock select: divide by 12 when 0, by 4 when 1
// [R10] timer zero clock select: divide by 12 when 0, by 4 when 1
// [R11] interrupt-one type bit: level-sensitive when 0, edge-sensitive when 1
// [R12] interrupt-zero type bit: edge-sensitive when 1, level-sensitive when 0
// [R13] each count readable and writable as separate low and high byte registers
// [R14] clearing run bit freezes counting and keeps both count bytes; in mode 11 the timer zero high byte follows timer one's run bit instead
// [R15] overflow sets flag; software write or vector acknowledge clears it
// [R16] edge mode sets flag on falling edge until cleared; level mode follows inverted pin
// [R17] timers advance only while run bit set; run bits reset cleared
module dtc_timer_unit (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // special function register port
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    output logic      [7:0] sfr_rdata,
    // interrupt vector acknowledges
    input  wire logic       vec_ack_zero_ovf,
    input  wire logic       vec_ack_one_ovf,
    input  wire logic       vec_ack_irq_zero,
    input  wire logic       vec_ack_irq_one,
    // pins
    input  wire logic       gate_irq_pin_zero,
    input  wire logic       gate_irq_pin_one,
    input  wire logic       count_pin_zero,
    input  wire logic       count_pin_one,
    // flags
    output logic            zero_overflow_flag,
    output logic            one_overflow_flag,
    output logic            ext_irq_zero_flag,
    output logic            ext_irq_one_flag
);
    import dtc_pkg::*;

    dtc_tick_if tk ();

    dtc_tick_gen u_tick (
        .mclk    (mclk),
        .reset_n (reset_n),
        .tk      (tk.gen)
    );

    assign tk.count_pin = {count_pin_one, count_pin_zero};

    logic [7:0] ctrl_q,  ctrl_d;
    logic [7:0] mode_q,  mode_d;
    logic [7:0] low0_q,  low0_d;
    logic [7:0] high0_q, high0_d;
    logic [7:0] low1_q,  low1_d;
    logic [7:0] high1_q, high1_d;
    logic [4:0] ckdiv_q, ckdiv_d;
    logic [1:0] irq_prev_q, irq_prev_d;
    logic [7:0] rdata_q, rdata_d;

    logic [1:0] gate_pin;
    logic [1:0] src_tick;
    logic [1:0] run_en;
    logic [1:0] irq_fall;
    dtc_mode_t  mode0, mode1;
    logic       split_high_en;
    logic [16:0] step0, step1;
    logic [8:0]  step_hi;

    // ************************************************************
    // count step: returns {overflow, high, low}
    // ************************************************************
    function automatic logic [16:0] cnt_step(input dtc_mode_t m, input logic [7:0] lo,
                                             input logic [7:0] hi);
        logic [5:0] p;
        logic [8:0] b;
        logic [16:0] w;
        p = {1'b0, lo[4:0]} + 6'd1;
        b = {1'b0, hi} + 9'd1;
        w = {1'b0, hi, lo} + 17'd1;
        cnt_step = {1'b0, hi, lo};
        case (m)
            DTC_MODE_PRESCALE: begin
                cnt_step = {1'b0, hi, lo[7:5], p[4:0]}; // [R5]
                if (p[5]) begin
                    cnt_step = {b, lo[7:5], p[4:0]};
                end
            end
            DTC_MODE_FULL16: begin
                cnt_step = w; // [R5]
            end
            DTC_MODE_RELOAD: begin
                b = {1'b0, lo} + 9'd1;
                cnt_step = {b[8], hi, b[8] ? hi : b[7:0]}; // [R6]
            end
            default: begin
                cnt_step = {1'b0, hi, lo};
            end
        endcase
    endfunction

    // ************************************************************
    // count enables
    // ************************************************************
    generate
        for (genvar t = 0; t < 2; t++) begin : g_en
            localparam int MB = 4 * t;
            always_comb begin
                src_tick[t] = ckdiv_q[DTC_CKDIV_SEL0 + t] ? tk.tick_div4 // [R9] [R10]
                            : tk.tick_div12;
                if (mode_q[MB + DTC_MODE_CT]) begin
                    src_tick[t] = tk.count_fall[t]; // [R3] [R4]
                end
                run_en[t] = ctrl_q[DTC_CTRL_RUN0 + 2 * t] // [R14] [R17]
                          & (~mode_q[MB + DTC_MODE_GATE] | gate_pin[t]) // [R1] [R2]
                          & src_tick[t];
            end
        end
    endgenerate

    assign gate_pin = {gate_irq_pin_one, gate_irq_pin_zero};
    assign irq_fall = irq_prev_q & ~gate_pin;
    assign mode0    = dtc_mode_t'(mode_q[1:0]);
    assign mode1    = dtc_mode_t'(mode_q[5:4]);
    // split high half runs on timer zero's internal clock, gated by timer one's run bit
    assign split_high_en = ctrl_q[DTC_CTRL_RUN1]
                         & (ckdiv_q[DTC_CKDIV_SEL0] ? tk.tick_div4 : tk.tick_div12);
    assign step0   = cnt_step(mode0, low0_q, high0_q);
    assign step1   = cnt_step(mode1, low1_q, high1_q);
    assign step_hi = {1'b0, high0_q} + 9'd1;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        ctrl_d     = ctrl_q;
        mode_d     = mode_q;
        low0_d     = low0_q;
        high0_d    = high0_q;
        low1_d     = low1_q;
        high1_d    = high1_q;
        ckdiv_d    = ckdiv_q;
        irq_prev_d = gate_pin;

        // timer zero
        if (mode0 == DTC_MODE_SPLIT) begin
            if (run_en[0]) begin
                low0_d = low0_q + 8'd1; // [R8]
            end
            if (split_high_en) begin
                high0_d = step_hi[7:0]; // [R8]
            end
        end else if (run_en[0]) begin
            {high0_d, low0_d} = step0[15:0];
        end

        // timer one; mode 11 leaves the count alone
        if (run_en[1] && mode1 != DTC_MODE_SPLIT) begin // [R7]
            {high1_d, low1_d} = step1[15:0];
        end

        // software writes win over a count step in the same cycle
        if (sfr_wr) begin
            case (sfr_addr)
                DTC_ADDR_CTRL:  ctrl_d  = sfr_wdata;
                DTC_ADDR_MODE:  mode_d  = sfr_wdata;
                DTC_ADDR_LOW0:  low0_d  = sfr_wdata; // [R13]
                DTC_ADDR_HIGH0: high0_d = sfr_wdata; // [R13]
                DTC_ADDR_LOW1:  low1_d  = sfr_wdata; // [R13]
                DTC_ADDR_HIGH1: high1_d = sfr_wdata; // [R13]
                DTC_ADDR_CKDIV: ckdiv_d = sfr_wdata[4:0];
                default: begin
                end
            endcase
        end

        // vector acknowledges clear, then hardware sets win over any clear
        if (vec_ack_zero_ovf) ctrl_d[DTC_CTRL_OVF0] = 1'b0; // [R15]
        if (vec_ack_one_ovf)  ctrl_d[DTC_CTRL_OVF1] = 1'b0; // [R15]
        if (vec_ack_irq_zero) ctrl_d[DTC_CTRL_IRQF0] = 1'b0; // [R16]
        if (vec_ack_irq_one)  ctrl_d[DTC_CTRL_IRQF1] = 1'b0; // [R16]
        if (mode0 == DTC_MODE_SPLIT) begin
            // timer one loses its flag to the split high half
            if (run_en[0] && low0_q == 8'hff) ctrl_d[DTC_CTRL_OVF0] = 1'b1; // [R15]
            if (split_high_en && step_hi[8])  ctrl_d[DTC_CTRL_OVF1] = 1'b1; // [R8]
        end else begin
            if (run_en[0] && step0[16]) ctrl_d[DTC_CTRL_OVF0] = 1'b1; // [R15]
            if (run_en[1] && mode1 != DTC_MODE_SPLIT && step1[16]) begin
                ctrl_d[DTC_CTRL_OVF1] = 1'b1; // [R15]
            end
        end

        // external interrupt flags
        if (ctrl_q[DTC_CTRL_IRQT0]) begin
            if (irq_fall[0]) ctrl_d[DTC_CTRL_IRQF0] = 1'b1; // [R12] [R16]
        end else begin
            ctrl_d[DTC_CTRL_IRQF0] = ~gate_irq_pin_zero; // [R12] [R16]
        end
        if (ctrl_q[DTC_CTRL_IRQT1]) begin
            if (irq_fall[1]) ctrl_d[DTC_CTRL_IRQF1] = 1'b1; // [R11] [R16]
        end else begin
            ctrl_d[DTC_CTRL_IRQF1] = ~gate_irq_pin_one; // [R11] [R16]
        end
    end

    // ************************************************************
    // read mux, registered: data follows the address by one clock
    // ************************************************************
    always_comb begin
        case (sfr_addr)
            DTC_ADDR_CTRL:  rdata_d = ctrl_q;
            DTC_ADDR_MODE:  rdata_d = mode_q;
            DTC_ADDR_LOW0:  rdata_d = low0_q;
            DTC_ADDR_HIGH0: rdata_d = high0_q;
            DTC_ADDR_LOW1:  rdata_d = low1_q;
            DTC_ADDR_HIGH1: rdata_d = high1_q;
            DTC_ADDR_CKDIV: rdata_d = {3'h0, ckdiv_q};
            default:        rdata_d = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q     <= DTC_RST_CTRL; // [R17]
            mode_q     <= DTC_RST_MODE;
            low0_q     <= DTC_RST_COUNT;
            high0_q    <= DTC_RST_COUNT;
            low1_q     <= DTC_RST_COUNT;
            high1_q    <= DTC_RST_COUNT;
            ckdiv_q    <= DTC_RST_CKDIV;
            irq_prev_q <= DTC_RST_PIN;
            rdata_q    <= 8'h00;
        end else begin
            ctrl_q     <= ctrl_d;
            mode_q     <= mode_d;
            low0_q     <= low0_d;
            high0_q    <= high0_d;
            low1_q     <= low1_d;
            high1_q    <= high1_d;
            ckdiv_q    <= ckdiv_d;
            irq_prev_q <= irq_prev_d;
            rdata_q    <= rdata_d;
        end
    end

    assign sfr_rdata          = rdata_q;
    assign zero_overflow_flag = ctrl_q[DTC_CTRL_OVF0];
    assign one_overflow_flag  = ctrl_q[DTC_CTRL_OVF1];
    assign ext_irq_zero_flag  = ctrl_q[DTC_CTRL_IRQF0];
    assign ext_irq_one_flag   = ctrl_q[DTC_CTRL_IRQF1];

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    logic cnt_wr;
    assign cnt_wr = sfr_wr && (sfr_addr inside {DTC_ADDR_LOW0, DTC_ADDR_HIGH0,
                                                DTC_ADDR_LOW1, DTC_ADDR_HIGH1});

    a_stop_freezes: assert property (!ctrl_q[DTC_CTRL_RUN0] && mode0 != DTC_MODE_SPLIT // [R14]
        && !cnt_wr |=> $stable({high0_q, low0_q})) else $error("stopped timer zero moved");
    a_stop_one: assert property (!ctrl_q[DTC_CTRL_RUN1] && !cnt_wr // [R14]
        |=> $stable({high1_q, low1_q})) else $error("stopped timer one moved");
    a_gate_blocks: assert property (mode_q[DTC_MODE_GATE] && !gate_irq_pin_zero // [R2]
        && mode0 != DTC_MODE_SPLIT && !cnt_wr |=> $stable({high0_q, low0_q}))
        else $error("gated timer zero moved");
    a_one_no_gate: assert property (ctrl_q[DTC_CTRL_RUN1] && !mode_q[7] && !mode_q[6] // [R1]
        && mode1 == DTC_MODE_FULL16 && tk.tick_div12 && !ckdiv_q[DTC_CKDIV_SEL1] && !cnt_wr
        |=> {high1_q, low1_q} == $past({high1_q, low1_q}) + 16'd1)
        else $error("ungated timer one did not step");
    a_pin_count: assert property (mode_q[DTC_MODE_CT] && !tk.count_fall[0] // [R4]
        && mode0 != DTC_MODE_SPLIT && !cnt_wr |=> $stable({high0_q, low0_q}))
        else $error("counter zero moved without pin edge");
    a_wrap_flag: assert property (run_en[0] && mode0 == DTC_MODE_FULL16 // [R15]
        && {high0_q, low0_q} == 16'hffff && !cnt_wr |=> ctrl_q[DTC_CTRL_OVF0]
        && {high0_q, low0_q} == 16'h0000) else $error("16-bit wrap lost");
    a_reload_low: assert property (run_en[0] && mode0 == DTC_MODE_RELOAD // [R6]
        && low0_q == 8'hff && !cnt_wr |=> low0_q == high0_q) else $error("reload missed");
    a_one_halt: assert property (mode1 == DTC_MODE_SPLIT && !cnt_wr // [R7]
        |=> $stable({high1_q, low1_q})) else $error("halted timer one moved");
    a_split_high: assert property (mode0 == DTC_MODE_SPLIT && split_high_en // [R8]
        && high0_q == 8'hff && !cnt_wr |=> one_overflow_flag && high0_q == 8'h00)
        else $error("split high half wrap lost");
    a_level_follow: assert property (!ctrl_q[DTC_CTRL_IRQT0] && !(sfr_wr // [R12]
        && sfr_addr == DTC_ADDR_CTRL) |=> ext_irq_zero_flag == !$past(gate_irq_pin_zero))
        else $error("level flag not following pin");
    a_edge_hold: assert property (ctrl_q[DTC_CTRL_IRQT1] && irq_fall[1] // [R11]
        |=> ext_irq_one_flag) else $error("falling edge not caught");
    a_byte_write: assert property (sfr_wr && sfr_addr == DTC_ADDR_HIGH1 // [R13]
        |=> high1_q == $past(sfr_wdata)) else $error("high byte write lost");

    c_wrap16:  cover property (run_en[0] && mode0 == DTC_MODE_FULL16 && step0[16]);
    c_reload:  cover property (run_en[1] && mode1 == DTC_MODE_RELOAD && step1[16]);
    c_edge:    cover property (ctrl_q[DTC_CTRL_IRQT0] && irq_fall[0]);
    c_split:   cover property (mode0 == DTC_MODE_SPLIT && split_high_en && step_hi[8]);
endmodule

/* verif/dtc_pin_model.sv */
`timescale 1ns/1ns
module dtc_pin_model (
    // clock
    input  wire logic mclk,
    // pins toward the timer unit
    output logic      gate_irq_pin_zero,
    output logic      gate_irq_pin_one,
    output logic      count_pin_zero,
    output logic      count_pin_one
);
    // port pins idle high, as a pulled-up input would
    logic [1:0] gate_lvl = 2'h3;
    logic [1:0] cnt_lvl  = 2'h3;

    assign gate_irq_pin_zero = gate_lvl[0];
    assign gate_irq_pin_one  = gate_lvl[1];
    assign count_pin_zero    = cnt_lvl[0];
    assign count_pin_one     = cnt_lvl[1];

    task automatic set_gate(input int idx, input logic v);
        @(negedge mclk);
        gate_lvl[idx] = v;
    endtask

    // two cycles low, two high: each pulse is one clean falling edge
    task automatic pulse(input int idx, input int n);
        repeat (n) begin
            @(negedge mclk);
            cnt_lvl[idx] = 1'b0;
            repeat (2) @(negedge mclk);
            cnt_lvl[idx] = 1'b1;
            @(negedge mclk);
        end
    endtask
endmodule

/* verif/dtc_timer_unit_bench.sv */
`timescale 1ns/1ns
module dtc_timer_unit_bench;
    import dtc_pkg::*;
    logic       mclk      = 1'b0;
    logic       reset_n   = 1'b0;
    logic [7:0] sfr_addr  = 8'h00;
    logic       sfr_wr    = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [3:0] ack       = 4'h0;
    logic       gate_irq_pin_zero, gate_irq_pin_one, count_pin_zero, count_pin_one;
    logic       zero_overflow_flag, one_overflow_flag, ext_irq_zero_flag, ext_irq_one_flag;
    logic [1:0] ext_flags;
    int         err_count   = 0;
    int         check_count = 0;
    // ckdiv, mode, control, address read, expected low byte
    logic [39:0] rows [6] = '{40'h01_01_10_8a_0a, 40'h08_01_10_8a_1e, 40'h10_10_40_8b_1e,
                              40'h00_10_40_8b_0a, 40'h08_09_10_8a_00, 40'h08_09_10_8a_1e};

    assign ext_flags = {ext_irq_one_flag, ext_irq_zero_flag};

    always #5 mclk = ~mclk;

    dtc_timer_unit i_dtc_timer_unit (
        .mclk(mclk), .reset_n(reset_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .vec_ack_zero_ovf(ack[0]),
        .vec_ack_one_ovf(ack[1]), .vec_ack_irq_zero(ack[2]), .vec_ack_irq_one(ack[3]),
        .gate_irq_pin_zero(gate_irq_pin_zero), .gate_irq_pin_one(gate_irq_pin_one),
        .count_pin_zero(count_pin_zero), .count_pin_one(count_pin_one),
        .zero_overflow_flag(zero_overflow_flag), .one_overflow_flag(one_overflow_flag),
        .ext_irq_zero_flag(ext_irq_zero_flag), .ext_irq_one_flag(ext_irq_one_flag));

    dtc_pin_model i_dtc_pin_model (
        .mclk(mclk), .gate_irq_pin_zero(gate_irq_pin_zero),
        .gate_irq_pin_one(gate_irq_pin_one), .count_pin_zero(count_pin_zero),
        .count_pin_one(count_pin_one));

    // ************************************************************
    // access tasks
    // ************************************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic fc(input string what, input logic seen, input logic exp);
        check(what, {7'h00, seen}, {7'h00, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge mclk);
        sfr_wr    = 1'b0;
    endtask

    // read data is registered: present the address, sample one edge later
    task automatic rc(input logic [7:0] a, input logic [7:0] exp);
        @(negedge mclk);
        sfr_addr = a;
        @(negedge mclk);
        check($sformatf("register %h", a), sfr_rdata, exp);
    endtask

    task automatic ackp(input int i);
        @(negedge mclk);
        ack[i] = 1'b1;
        @(negedge mclk);
        ack[i] = 1'b0;
    endtask

    task automatic zero_counts;
        for (int i = 0; i < 4; i++) wr(8'h8a + i[7:0], 8'h00);
    endtask

    // run bits live for exactly n edges, so any tick phase gives n/12 or n/4 steps
    task automatic run_for(input logic [7:0] ctrl, input int n);
        wr(DTC_ADDR_CTRL, ctrl);
        repeat (n - 2) @(negedge mclk);
        wr(DTC_ADDR_CTRL, 8'h00);
    endtask

    task automatic conclude;
        if (err_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge mclk);
        err_count++;
        conclude();
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        reset_n = 1'b1;
        for (int a = 8'h87; a <= 8'h8f; a++) begin
            rc(a[7:0], (a == 8'h8e) ? 8'h01 : 8'h00);
        end
        for (int i = 0; i < 4; i++) wr(8'h8a + i[7:0], 8'h11 * (i[7:0] + 8'h01));
        for (int i = 0; i < 4; i++) rc(8'h8a + i[7:0], 8'h11 * (i[7:0] + 8'h01));
        wr(DTC_ADDR_CKDIV, 8'hff);
        rc(DTC_ADDR_CKDIV, 8'h1f);
        i_dtc_pin_model.set_gate(1, 1'b0);
        for (int r = 0; r < 6; r++) begin
            i_dtc_pin_model.set_gate(0, r != 4);
            zero_counts();
            wr(DTC_ADDR_CKDIV, rows[r][39:32]);
            wr(DTC_ADDR_MODE, rows[r][31:24]);
            run_for(rows[r][23:16], 120);
            rc(rows[r][15:8], rows[r][7:0]);
            repeat (30) @(negedge mclk);
            rc(rows[r][15:8], rows[r][7:0]);
            rc(rows[r][15:8] + 8'h02, 8'h00);
        end
        zero_counts();
        wr(DTC_ADDR_MODE, 8'h03);
        run_for(8'h50, 120);
        rc(DTC_ADDR_LOW0, 8'h1e);
        rc(DTC_ADDR_HIGH0, 8'h1e);
        // four clock edges hold exactly one fast tick, one step of the high half
        wr(DTC_ADDR_HIGH0, 8'hff);
        wr(DTC_ADDR_CTRL, 8'h40);
        repeat (4) @(negedge mclk);
        fc("one_overflow_flag", one_overflow_flag, 1'b1);
        wr(DTC_ADDR_MODE, 8'h30);
        wr(DTC_ADDR_LOW1, 8'h33);
        run_for(8'h40, 120);
        rc(DTC_ADDR_LOW1, 8'h33);
        // pin-counted steps need no tick phase
        zero_counts();
        wr(DTC_ADDR_MODE, 8'h55);
        wr(DTC_ADDR_CTRL, 8'h50);
        i_dtc_pin_model.pulse(0, 5);
        i_dtc_pin_model.pulse(1, 3);
        rc(DTC_ADDR_LOW0, 8'h05);
        rc(DTC_ADDR_LOW1, 8'h03);
        wr(DTC_ADDR_MODE, 8'h05);
        wr(DTC_ADDR_LOW0, 8'hff);
        wr(DTC_ADDR_HIGH0, 8'hff);
        wr(DTC_ADDR_CTRL, 8'h10);
        i_dtc_pin_model.pulse(0, 1);
        fc("zero_overflow_flag", zero_overflow_flag, 1'b1);
        rc(DTC_ADDR_LOW0, 8'h00);
        rc(DTC_ADDR_HIGH0, 8'h00);
        ackp(0);
        fc("zero_overflow_flag", zero_overflow_flag, 1'b0);
        wr(DTC_ADDR_MODE, 8'h06);
        wr(DTC_ADDR_HIGH0, 8'hf0);
        wr(DTC_ADDR_LOW0, 8'hfe);
        i_dtc_pin_model.pulse(0, 3);
        rc(DTC_ADDR_LOW0, 8'hf1);
        rc(DTC_ADDR_HIGH0, 8'hf0);
        fc("zero_overflow_flag", zero_overflow_flag, 1'b1);
        wr(DTC_ADDR_CTRL, 8'h00);
        fc("zero_overflow_flag", zero_overflow_flag, 1'b0);
        wr(DTC_ADDR_MODE, 8'h04);
        wr(DTC_ADDR_LOW0, 8'hff);
        wr(DTC_ADDR_HIGH0, 8'h00);
        wr(DTC_ADDR_CTRL, 8'h10);
        i_dtc_pin_model.pulse(0, 1);
        rc(DTC_ADDR_LOW0, 8'he0);
        rc(DTC_ADDR_HIGH0, 8'h01);
        // timer one counting pin edges in reload mode
        wr(DTC_ADDR_MODE, 8'h60);
        wr(DTC_ADDR_LOW1, 8'hff);
        wr(DTC_ADDR_HIGH1, 8'h5a);
        wr(DTC_ADDR_CTRL, 8'h40);
        i_dtc_pin_model.pulse(1, 1);
        fc("one_overflow_flag", one_overflow_flag, 1'b1);
        rc(DTC_ADDR_LOW1, 8'h5a);
        ackp(1);
        fc("one_overflow_flag", one_overflow_flag, 1'b0);
        // external interrupt pins: edge kind first, then level kind
        i_dtc_pin_model.set_gate(0, 1'b1);
        i_dtc_pin_model.set_gate(1, 1'b1);
        wr(DTC_ADDR_CTRL, 8'h05);
        for (int i = 0; i < 2; i++) begin
            i_dtc_pin_model.set_gate(i, 1'b0);
            repeat (3) @(negedge mclk);
            fc("ext flag edge", ext_flags[i], 1'b1);
            i_dtc_pin_model.set_gate(i, 1'b1);
            repeat (3) @(negedge mclk);
            fc("ext flag held", ext_flags[i], 1'b1);
            ackp(2 + i);
            fc("ext flag acked", ext_flags[i], 1'b0);
        end
        wr(DTC_ADDR_CTRL, 8'h00);
        for (int i = 0; i < 2; i++) begin
            i_dtc_pin_model.set_gate(i, 1'b0);
            repeat (3) @(negedge mclk);
            fc("ext flag level", ext_flags[i], 1'b1);
            i_dtc_pin_model.set_gate(i, 1'b1);
            repeat (3) @(negedge mclk);
            fc("ext flag level", ext_flags[i], 1'b0);
        end
        conclude();
    end
endmodule
